/* inc/ldr_pkg.sv */
package ldr_pkg;

   // Clock rate and derived cycle counts.
   localparam int CLK_MHZ = 10;
   localparam int FILT_US = 150;
   localparam int FILT_CYC = FILT_US * CLK_MHZ;
   localparam int NARROW_US = 250;
   localparam int NARROW_CYC = NARROW_US * CLK_MHZ;
   localparam int SAMPLE_US = 78;
   localparam int SAMPLE_CYC = SAMPLE_US * CLK_MHZ;
   localparam int HOLD_US = 1000;
   localparam int HOLD_CYC = HOLD_US * CLK_MHZ;
   localparam int GND_MS = 100;
   localparam int GND_CYC = GND_MS * 1000 * CLK_MHZ;
   localparam int OVP_TIMEOUT_MS = 1000;
   localparam int OVP_CYC = OVP_TIMEOUT_MS * 1000 * CLK_MHZ;

   // Counter widths.
   localparam int FILT_W = 12;
   localparam int PRE_W = 10;
   localparam int HOLD_W = 14;
   localparam int CYC_W = 24;
   localparam int OVP_W = 24;

   // Reference codes, full scale 127 levels over 0 V to 1 V.
   localparam int CODE_W = 7;
   localparam logic [6:0] CODE_MAX = 7'h7f;
   localparam logic [6:0] CODE_START = 7'h32;
   localparam logic [6:0] CODE_GND = 7'h32;
   localparam logic [6:0] CODE_LOST = 7'h2a;
   localparam logic [6:0] DIM_OFS = 7'h23;
   localparam logic [6:0] DIM_MAX = 7'h3f;
   localparam logic [6:0] BAL_STEP = 7'h04;
   localparam logic [6:0] HOLD_STEP = 7'h08;

   // Asymmetry threshold in percent of the longer half-cycle.
   localparam logic [7:0] BAL_PCT = 8'h14;
   localparam logic [7:0] PCT_FULL = 8'h64;

   typedef enum logic [1:0] {
      LDR_START = 2'b00,
      LDR_DIM = 2'b01,
      LDR_LOST = 2'b10,
      LDR_GND = 2'b11
   } ldr_mode_t;

endpackage

/* core/ldr_filt.sv */
`timescale 1ns/1ns
`default_nettype none

module ldr_filt
   import ldr_pkg::*;
#(
   parameter int HOLD = FILT_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Raw comparator pin and filtered level.
   input wire logic raw,
   output logic level
);

   if (HOLD < 1 || HOLD >= 2 ** FILT_W) begin : g_chk
      $error("ldr_filt: HOLD out of range");
   end

   localparam logic [FILT_W-1:0] LAST = FILT_W'(HOLD - 1);

   typedef struct packed {
      logic s1;
      logic s2;
      logic level;
      logic [FILT_W-1:0] cnt;
   } ldr_filt_t;

   ldr_filt_t r;
   ldr_filt_t next_r;

   ////////////////////////////////////////////////////////////////////////////
   // The level changes only after the synchronised pin differs for HOLD cycles.
   always_comb begin
      next_r = r;
      next_r.s1 = raw;
      next_r.s2 = r.s1;
      if (r.s2 == r.level) begin
         next_r.cnt = '0;
      end else if (r.cnt == LAST) begin
         next_r.level = r.s2;
         next_r.cnt = '0;
      end else begin
         next_r.cnt = r.cnt + 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign level = r.level;

endmodule

`default_nettype wire

/* core/ldr_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - When consecutive half-cycle lengths differ by more than 20%, the next half-cycle code is nudged once by 4 to equalise energy.
// - After the filtered angle-sense fall, the code is raised for a short hold interval.
// - A pulse too short to measure forces code 42 until a valid pulse returns or the input is grounded.
// - With the angle-sense input grounded, balancing and active hold are not performed.
// - With the angle-sense input grounded, the code is a static 50.
// - An active thermal-shutdown flag holds the gate enable low.
// - When the thermal flag clears, switching resumes unless an overvoltage trip or latch still holds the gate enable low.
// - A supply overvoltage trip disables the gate enable.
// - After an overvoltage trip the gate stays off until 1 s has passed and then the supply has fallen 0.5 V below the trip.
// - The reference is a 7-bit code of 127 levels, code/127 of 1 V.
// - An angle-sense change is recorded only after it persists for about 150 us.

module ldr_ctrl
   import ldr_pkg::*;
#(
   parameter int OVP_TIMEOUT = OVP_CYC,
   parameter int GND_TIME = GND_CYC,
   parameter int HOLD_TIME = HOLD_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Asynchronous comparator and fault flags.
   input wire logic angle_sense_input,
   input wire logic thermal_shutdown,
   input wire logic supply_overvoltage_trip,
   input wire logic supply_ovp_release,
   // Converter stage controls.
   output logic [CODE_W-1:0] ref_code,
   output logic gate_en
);

   if (OVP_TIMEOUT < 1 || OVP_TIMEOUT >= 2 ** OVP_W) begin : g_chk_ovp
      $error("ldr_ctrl: OVP_TIMEOUT out of range");
   end
   if (GND_TIME <= NARROW_CYC || GND_TIME >= 2 ** CYC_W) begin : g_chk_gnd
      $error("ldr_ctrl: GND_TIME out of range");
   end
   if (HOLD_TIME < 1 || HOLD_TIME >= 2 ** HOLD_W) begin : g_chk_hold
      $error("ldr_ctrl: HOLD_TIME out of range");
   end

   localparam logic [OVP_W-1:0] OVP_LAST = OVP_W'(OVP_TIMEOUT - 1);
   localparam logic [CYC_W-1:0] GND_LAST = CYC_W'(GND_TIME - 1);
   localparam logic [CYC_W-1:0] NARROW_LIM = CYC_W'(NARROW_CYC);
   localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_TIME);
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(SAMPLE_CYC - 1);
   localparam logic [CYC_W-1:0] CYC_SAT = '1;

   typedef struct packed {
      logic th_s1;
      logic th_s2;
      logic ov_s1;
      logic ov_s2;
      logic rl_s1;
      logic rl_s2;
      logic asn_d;
      ldr_mode_t mode;
      logic [PRE_W-1:0] pre;
      logic [7:0] len;
      logic [CYC_W-1:0] cyc;
      logic [7:0] prev_len;
      logic have_prev;
      logic [CODE_W-1:0] level;
      logic [HOLD_W-1:0] hold_cnt;
      logic ovp_lat;
      logic ovp_done;
      logic [OVP_W-1:0] ovp_cnt;
      logic [CODE_W-1:0] ref_code;
      logic gate_en;
   } ldr_state_t;

   localparam ldr_state_t RST_VAL = '{
      th_s1: 1'b0, th_s2: 1'b0, ov_s1: 1'b0, ov_s2: 1'b0, rl_s1: 1'b0, rl_s2: 1'b0,
      asn_d: 1'b0, mode: LDR_START, pre: '0, len: '0, cyc: '0, prev_len: '0,
      have_prev: 1'b0, level: CODE_START, hold_cnt: '0, ovp_lat: 1'b0,
      ovp_done: 1'b0, ovp_cnt: '0, ref_code: CODE_START, gate_en: 1'b0
   };

   ldr_state_t r;
   ldr_state_t next_r;
   logic asn_f;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronised and filtered angle-sense level.
   ldr_filt #(
      .HOLD(FILT_CYC)
   ) u_filt (
      .mclk(mclk),
      .srst(srst),
      .raw(angle_sense_input),
      .level(asn_f)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Saturating add and subtract on the 7-bit code range.
   function automatic logic [CODE_W-1:0] code_add(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
      logic [CODE_W:0] s;
      s = {1'b0, a} + {1'b0, b};
      code_add = s[CODE_W] ? CODE_MAX : s[CODE_W-1:0];
   endfunction

   function automatic logic [CODE_W-1:0] code_sub(input logic [CODE_W-1:0] a, input logic [CODE_W-1:0] b);
      code_sub = (a > b) ? a - b : '0;
   endfunction

   // Dimming level: half the measured length plus offset, clamped.
   function automatic logic [CODE_W-1:0] dim_code(input logic [7:0] len);
      logic [CODE_W:0] s;
      s = {1'b0, DIM_OFS} + {1'b0, len[7:1]};
      dim_code = (s > {1'b0, DIM_MAX}) ? DIM_MAX : s[CODE_W-1:0];
   endfunction

   // The coming half-cycle has the polarity of the previous one.
   function automatic logic [CODE_W-1:0] balance(input logic [CODE_W-1:0] base, input logic [7:0] prv,
                                                 input logic [7:0] cur);
      logic [7:0] diff;
      logic [7:0] big;
      logic [15:0] lhs;
      logic [15:0] rhs;
      diff = (prv > cur) ? prv - cur : cur - prv;
      big = (prv > cur) ? prv : cur;
      lhs = diff * PCT_FULL;
      rhs = big * BAL_PCT;
      if (lhs <= rhs) begin
         balance = base;
      end else if (prv < cur) begin
         balance = code_add(base, BAL_STEP);
      end else begin
         balance = code_sub(base, BAL_STEP);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic.
   always_comb begin
      logic rise;
      logic fall;
      rise = 1'b0;
      fall = 1'b0;
      next_r = r;
      next_r.th_s1 = thermal_shutdown;
      next_r.th_s2 = r.th_s1;
      next_r.ov_s1 = supply_overvoltage_trip;
      next_r.ov_s2 = r.ov_s1;
      next_r.rl_s1 = supply_ovp_release;
      next_r.rl_s2 = r.rl_s1;
      next_r.asn_d = asn_f;
      rise = asn_f & ~r.asn_d;
      fall = ~asn_f & r.asn_d;

      // Pulse length in line samples and raw cycles of the present level.
      if (rise || fall) begin
         next_r.cyc = '0;
         next_r.pre = '0;
      end else if (r.cyc != CYC_SAT) begin
         next_r.cyc = r.cyc + 1'b1;
      end
      if (rise) begin
         next_r.len = '0;
      end else if (asn_f && !rise) begin
         if (r.pre == PRE_LAST) begin
            next_r.pre = '0;
            if (r.len != 8'hff) begin
               next_r.len = r.len + 1'b1;
            end
         end else begin
            next_r.pre = r.pre + 1'b1;
         end
      end

      if (r.hold_cnt != '0) begin
         next_r.hold_cnt = r.hold_cnt - 1'b1;
      end

      // Mode decisions happen at the end of each pulse or after a long low, independent of faults.
      if (fall) begin
         if (r.cyc < NARROW_LIM) begin
            next_r.mode = LDR_LOST;
            next_r.level = CODE_LOST;
            next_r.have_prev = 1'b0;
            next_r.hold_cnt = '0;
         end else begin
            next_r.mode = LDR_DIM;
            next_r.level = r.have_prev ? balance(dim_code(r.len), r.prev_len, r.len) : dim_code(r.len);
            next_r.prev_len = r.len;
            next_r.have_prev = 1'b1;
            next_r.hold_cnt = HOLD_LOAD;
         end
      end else if (!asn_f && r.cyc >= GND_LAST && r.mode != LDR_GND) begin
         next_r.mode = LDR_GND;
         next_r.level = CODE_GND;
         next_r.have_prev = 1'b0;
         next_r.hold_cnt = '0;
      end

      case (r.mode)
         LDR_START: next_r.ref_code = CODE_START;
         LDR_LOST: next_r.ref_code = CODE_LOST;
         LDR_GND: next_r.ref_code = CODE_GND;
         LDR_DIM: next_r.ref_code = (r.hold_cnt != '0) ? code_add(r.level, HOLD_STEP) : r.level;
         default: next_r.ref_code = CODE_START;
      endcase

      // Overvoltage latch: timeout first, then the release comparator.
      if (r.ov_s2) begin
         next_r.ovp_lat = 1'b1;
         next_r.ovp_done = 1'b0;
         next_r.ovp_cnt = '0;
      end else if (r.ovp_lat) begin
         if (!r.ovp_done) begin
            if (r.ovp_cnt == OVP_LAST) begin
               next_r.ovp_done = 1'b1;
            end else begin
               next_r.ovp_cnt = r.ovp_cnt + 1'b1;
            end
         end else if (r.rl_s2) begin
            next_r.ovp_lat = 1'b0;
            next_r.ovp_done = 1'b0;
            next_r.ovp_cnt = '0;
         end
      end

      // Faults gate the drive only; reference state keeps running.
      next_r.gate_en = !r.th_s2 && !r.ov_s2 && !r.ovp_lat;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         r <= RST_VAL;
      end else begin
         r <= next_r;
      end
   end

   assign ref_code = r.ref_code;
   assign gate_en = r.gate_en;

endmodule

`default_nettype wire

/* bench/ldr_ctrl_chk.sv */
`timescale 1ns/1ns
`default_nettype none

module ldr_chk
   import ldr_pkg::*;
#(
   parameter int OVP_TIMEOUT = OVP_CYC,
   parameter int GND_TIME = GND_CYC,
   parameter int HOLD_TIME = HOLD_CYC
) (
   // Clock and reset.
   input wire logic mclk,
   input wire logic srst,
   // Watched inputs.
   input wire logic angle_sense_input,
   input wire logic thermal_shutdown,
   input wire logic supply_overvoltage_trip,
   input wire logic supply_ovp_release,
   // Watched outputs.
   input wire logic [CODE_W-1:0] ref_code,
   input wire logic gate_en
);
   ////////////////////////////////////////////////////////////////////////////
   // Run lengths; short low gaps do not clear the high run, as the filter ignores them.
   int ovp_low;
   int hi_run;
   int lo_run;
   always_ff @(posedge mclk) begin
      if (srst) begin
         ovp_low <= 1000000000;
         hi_run <= 0;
         lo_run <= 0;
      end else begin
         ovp_low <= supply_overvoltage_trip ? 0 : (ovp_low < 1000000000 ? ovp_low + 1 : ovp_low);
         hi_run <= angle_sense_input ? hi_run + 1 : (lo_run > FILT_CYC + 40 ? 0 : hi_run);
         lo_run <= angle_sense_input ? 0 : lo_run + 1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (srst);

   a_reset_code: assert property ($fell(srst) |-> ref_code == 7'h32 ##1 ref_code == 7'h32)
      else $error("start code wrong");
   a_reset_gate: assert property ($fell(srst) |-> !gate_en)
      else $error("gate on at reset exit");
   a_therm_off: assert property (thermal_shutdown [*3] |=> !gate_en)
      else $error("gate on while hot");
   a_ovp_off: assert property (supply_overvoltage_trip [*3] |=> !gate_en)
      else $error("gate on during trip");
   a_therm_gate: assert property ($rose(gate_en) |-> !$past(thermal_shutdown, 3))
      else $error("gate rose while hot");
   a_ovp_wait: assert property ($rose(gate_en) |-> ovp_low >= OVP_TIMEOUT)
      else $error("gate rose before timeout");
   a_lost_code: assert property (lo_run == FILT_CYC + 30 && hi_run > FILT_CYC + 100
      && hi_run < NARROW_CYC - 100 |-> ref_code == 7'h2a)
      else $error("narrow pulse code wrong");
   a_gnd_code: assert property (lo_run >= GND_TIME + FILT_CYC + 10 |-> ref_code == 7'h32)
      else $error("grounded code wrong");
endmodule

`default_nettype wire

/* bench/ldr_line_model.sv */
`timescale 1ns/1ns
`default_nettype none

module ldr_line_model (
   // Clock and pulse shape.
   input wire logic mclk,
   input wire logic go,
   input wire logic [15:0] hi_cyc,
   input wire logic [15:0] hi_alt_cyc,
   input wire logic [15:0] per_cyc,
   // Comparator level towards the block.
   output logic angle_sense_input
);
   // Repeating line pulses; the comparator sits low while the line is idle.
   // Pulses alternate between hi_cyc and hi_alt_cyc high, each followed by the same low time.
   logic [15:0] n = 16'h0;
   logic odd = 1'b0;
   logic [15:0] cur_hi;
   initial angle_sense_input = 1'b0;
   assign cur_hi = odd ? hi_alt_cyc : hi_cyc;
   always @(negedge mclk) begin
      if (!go || n + 16'h1 >= cur_hi + per_cyc - hi_cyc) begin
         n <= 16'h0;
         odd <= go && !odd;
      end else begin
         n <= n + 16'h1;
      end
      angle_sense_input <= go && (n < cur_hi);
   end
endmodule

`default_nettype wire

/* bench/test_led_driver_reference_protection_control.sv */
`timescale 1ns/1ns
`default_nettype none

module test_led_driver_reference_protection_control;
   import ldr_pkg::*;
   localparam int OVP_T = 50;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic thermal_shutdown = 1'b0;
   logic supply_overvoltage_trip = 1'b0;
   logic supply_ovp_release = 1'b1;
   logic go = 1'b0;
   logic [15:0] hi_cyc = 16'h0;
   logic [15:0] hi_alt_cyc = 16'h0;
   logic [15:0] per_cyc = 16'h0;
   logic angle_sense_input;
   logic [CODE_W-1:0] ref_code;
   logic gate_en;
   int miscompares = 0;
   int compares = 0;

   always #50 mclk = ~mclk;

   ldr_ctrl #(.OVP_TIMEOUT(OVP_T), .GND_TIME(3000), .HOLD_TIME(20)) dut_u (.mclk, .srst, .angle_sense_input,
      .thermal_shutdown, .supply_overvoltage_trip, .supply_ovp_release, .ref_code, .gate_en);
   ldr_line_model line_u (.mclk, .go, .hi_cyc, .hi_alt_cyc, .per_cyc, .angle_sense_input);

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("[FAIL] %0t %s", $time, msg);
      end
   endtask

   task automatic wait_code(input logic [CODE_W-1:0] exp, input int lim);
      for (int i = 0; i < lim && ref_code !== exp; i++) @(negedge mclk);
      chk(ref_code === exp, "reference code");
      if (ref_code !== exp) finish_test();
   endtask

   task automatic wait_gate(input int lim);
      for (int i = 0; i < lim && gate_en !== 1'b1; i++) @(negedge mclk);
      chk(gate_en === 1'b1, "gate enable");
      if (gate_en !== 1'b1) finish_test();
   endtask

   // Restarts the line pulses with a new shape; every second pulse is alt cycles long.
   task automatic line(input logic [15:0] hi, input logic [15:0] alt, input logic [15:0] per);
      go <= 1'b0;
      hi_cyc <= hi;
      hi_alt_cyc <= alt;
      per_cyc <= per;
      @(negedge mclk);
      go <= 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_reset();
      repeat (8) @(negedge mclk);
      srst = 1'b0;
      chk(ref_code === 7'h32, "start code");
      wait_gate(4);
   endtask

   task automatic test_lost();
      line(16'h07d0, 16'h07d0, 16'h0fa0);
      wait_code(7'h2a, 8000);
      repeat (4000) @(negedge mclk);
      chk(ref_code === 7'h2a, "lost code held");
   endtask

   task automatic test_hold();
      line(16'h1f40, 16'h1f40, 16'h3e80);
      wait_code(7'h30, 40000);
      wait_code(7'h28, 30);
   endtask

   task automatic test_thermal();
      thermal_shutdown = 1'b1;
      repeat (4) @(negedge mclk);
      chk(gate_en === 1'b0, "gate while hot");
      chk(ref_code === 7'h28, "code while hot");
      thermal_shutdown = 1'b0;
      wait_gate(4);
   endtask

   task automatic test_ground();
      go <= 1'b0;
      wait_code(7'h32, 6000);
      line(16'h03e8, 16'h03e8, 16'hea60);
      repeat (1100) @(negedge mclk);
      go <= 1'b0;
      repeat (3000) @(negedge mclk);
      chk(ref_code === 7'h32, "glitch ignored, no hold");
   endtask

   // Alternate half-cycles of 8 and 5 samples, 2000 cycles low in between.
   task automatic test_balance();
      line(16'h18c4, 16'h0fa0, 16'h2094);
      wait_code(7'h21, 16000);
      wait_code(7'h33, 10000);
      wait_code(7'h2b, 30);
   endtask

   task automatic test_ovp();
      supply_overvoltage_trip = 1'b1;
      repeat (4) @(negedge mclk);
      chk(gate_en === 1'b0, "gate during trip");
      supply_overvoltage_trip = 1'b0;
      repeat (OVP_T) @(negedge mclk);
      chk(gate_en === 1'b0, "gate before timeout");
      wait_gate(10);
      supply_ovp_release = 1'b0;
      supply_overvoltage_trip = 1'b1;
      repeat (4) @(negedge mclk);
      supply_overvoltage_trip = 1'b0;
      repeat (OVP_T + 20) @(negedge mclk);
      chk(gate_en === 1'b0, "gate without release");
      chk(ref_code === 7'h32, "code after trip");
      supply_ovp_release = 1'b1;
      wait_gate(6);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      test_reset();
      test_lost();
      test_hold();
      test_thermal();
      test_ground();
      test_ovp();
      test_balance();
      finish_test();
   end
endmodule

bind ldr_ctrl ldr_chk #(.OVP_TIMEOUT(OVP_TIMEOUT), .GND_TIME(GND_TIME), .HOLD_TIME(HOLD_TIME)) chk_u (.mclk, .srst,
   .angle_sense_input, .thermal_shutdown, .supply_overvoltage_trip, .supply_ovp_release, .ref_code, .gate_en);

`default_nettype wire
